// ### asc_cfg.svh
/*
  constants of the scan and threshold control block: offsets,
  field positions, write masks, reset values and limits.
  assumes inclusion by bare name from the package and the module.
*/
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

// byte offsets on the register bus
`define ASC_OFF_CTL2 8'h00
`define ASC_OFF_TIMING 8'h04
`define ASC_OFF_SCAN 8'h08
`define ASC_OFF_INSEL 8'h0c
`define ASC_OFF_HIT_LO 8'h10
`define ASC_OFF_HIT_HI 8'h14
`define ASC_OFF_RUN 8'h18

// writable bits of each register and the common reset value
`define ASC_MASK_CTL2 16'h0001
`define ASC_MASK_TIMING 16'h9fff
`define ASC_MASK_SCAN 16'hf30f
`define ASC_MASK_INSEL 16'hffff
`define ASC_MASK_HIT_LO 16'hffff
`define ASC_MASK_HIT_HI 16'h0003
`define ASC_MASK_RUN 16'h80f2
`define ASC_RESET_VAL 16'h0000

// field positions
`define ASC_ALT_BIT 0
`define ASC_CLKSRC_BIT 15
`define ASC_EXTENDED_SAMPLING_FLAG_BIT 14
`define ASC_AUTO_SAMPLE_TIME_HI 12
`define ASC_AUTO_SAMPLE_TIME_LO 8
`define ASC_DIV_HI 7
`define ASC_DIV_LO 0
`define ASC_AUTO_SCAN_ENABLE_BIT 15
`define ASC_LOW_POWER_RETURN_BIT 14
`define ASC_CHARGE_UNIT_REQUEST_BIT 13
`define ASC_BAND_GAP_REQUEST_BIT 12
`define ASC_IRQM_HI 9
`define ASC_IRQM_LO 8
`define ASC_WM_HI 3
`define ASC_WM_LO 2
`define ASC_CM_HI 1
`define ASC_CM_LO 0
`define ASC_ON_BIT 15
`define ASC_SRC_HI 7
`define ASC_SRC_LO 4
`define ASC_SAMPLE_ENABLE_BIT 1

// largest legal divider code, above it is reserved
`define ASC_DIV_MAX 8'h3f
// sample source that runs the internal auto-convert counter
`define ASC_SRC_AUTO 4'h7
`define ASC_SRC_SOFT 4'h0

`endif

// ### asc_pkg.sv
/*
  types of the scan and threshold control block.
  assumes asc_cfg.svh is reachable by bare name.
*/
`include "asc_cfg.svh"

package asc_pkg;

  // sampling sequencer states
  typedef enum logic [1:0] {
    ASC_ST_IDLE = 2'b00,
    ASC_ST_SAMPLE = 2'b01,
    ASC_ST_CONVERT = 2'b10
  } asc_state_e;

  // result handed up by the converter core
  typedef struct packed {
    logic valid;
    logic last;
    logic [4:0] chan;
    logic [11:0] data;
  } asc_result_s;

  // threshold pair read from the result buffer for that channel
  typedef struct packed {
    logic [11:0] low;
    logic [11:0] high;
  } asc_window_s;

  // analog input multiplexer codes
  typedef struct packed {
    logic [2:0] neg;
    logic [4:0] pos;
  } asc_mux_s;

  // buffer write request
  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [11:0] data;
  } asc_bufwr_s;

endpackage

// ### asc_scan_ctrl.sv
/*
  converter control: conversion clock, sampling sequencer, input
  selection, threshold compare, hit flags and the axi4-lite slave.
  assumes the analog core supplies results synchronous to aclk and a
  one-cycle rc clock tick, and that the buffer returns the threshold
  pair for the channel of the result in the same cycle.
*/
// Functional notes
// - alternate on: sample A selections then B, alternating; off: A only
// - clock source bit set picks rc tick, clear divides system clock
// - extended sampling flag high while sampling continues after enable cleared
// - auto sample lasts auto_sample_time conversion clock periods, 0 to 31
// - conversion clock period is (divider + 1) cycles, codes above 0x3f reserved
// - auto scan enable turns threshold detect scanning on or off
// - low power return drops full power after a scan ends
// - charge unit request enables charge unit while converter on and active
// - band gap request enables band gap while converter on and active
// - irq mode: 11 sequence and compare, 10 compare, 01 sequence, 00 none
// - write mode 10 compares only, never saves; 11 reserved
// - write mode 01 saves result only on a match
// - write mode 00 saves every result
// - compare 11 outside window, 10 inside window of buffer pair
// - compare 01 greater than, 00 less than buffer value
// - negative code 000 picks ground, 001 to 111 picks inputs 0 to 6
// - positive codes pick inputs 0-15, floating, band gap and rails
// - sample A fields use the same codes as sample B fields
// - compare 11 sets hit on buffer write or match
// - other compare modes set hit only on match; missing channels read zero
// - auto-convert source ends sampling by counter and starts conversion
// - sample enable one means sampling, zero means holding
`timescale 1ns/1ps
`default_nettype none

module asc_scan_ctrl
  import asc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rc_clk_tick,
  input wire logic trigger_event,
  input wire asc_result_s result_in,
  input wire asc_window_s window_in,
  output logic conv_clk_tick,
  output logic sampling,
  output logic conv_start,
  output asc_mux_s mux_sel,
  output asc_bufwr_s buf_write,
  output logic threshold_event,
  output logic full_power,
  output logic charge_unit_enable,
  output logic band_gap_enable
);

  // byte-lane merge restricted to the writable bits
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] st,
                                        input logic [15:0] msk);
    logic [15:0] v;
    v = old;
    if (st[0]) v[7:0] = wd[7:0];
    if (st[1]) v[15:8] = wd[15:8];
    merge = v & msk;
  endfunction

  // threshold compare against the buffer value or pair
  function automatic logic cmp_match(input logic [1:0] cm,
                                     input logic [11:0] r,
                                     input asc_window_s w);
    logic in_win;
    in_win = (r >= w.low) && (r <= w.high);
    case (cm)
      2'h3: cmp_match = !in_win;
      2'h2: cmp_match = in_win;
      2'h1: cmp_match = r > w.low;
      default: cmp_match = r < w.low;
    endcase
  endfunction

  logic [15:0] ctl2_q, timing_q, scan_q, insel_q, run_q;
  logic [15:0] hit_lo_q;
  logic [1:0] hit_hi_q;
  asc_state_e state_q;
  logic [7:0] div_cnt_q;
  logic [4:0] auto_sample_time_cnt_q;
  logic alt_b_q, match_seen_q, ext_q;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic aw_ok_q, w_ok_q;

  // field views
  logic conv_on, sample_enable, auto_scan, lp_ret, src_rc;
  logic [3:0] src;
  logic [4:0] auto_sample_time;
  logic [7:0] div_lim;
  logic [1:0] wm, cm, irqm;
  assign conv_on = run_q[`ASC_ON_BIT];
  assign sample_enable = run_q[`ASC_SAMPLE_ENABLE_BIT];
  assign src = run_q[`ASC_SRC_HI:`ASC_SRC_LO];
  assign src_rc = timing_q[`ASC_CLKSRC_BIT];
  assign auto_sample_time = timing_q[`ASC_AUTO_SAMPLE_TIME_HI:`ASC_AUTO_SAMPLE_TIME_LO];
  assign auto_scan = scan_q[`ASC_AUTO_SCAN_ENABLE_BIT];
  assign lp_ret = scan_q[`ASC_LOW_POWER_RETURN_BIT];
  assign irqm = scan_q[`ASC_IRQM_HI:`ASC_IRQM_LO];
  assign wm = scan_q[`ASC_WM_HI:`ASC_WM_LO];
  assign cm = scan_q[`ASC_CM_HI:`ASC_CM_LO];
  // reserved divider codes clamp to the largest legal one
  assign div_lim = (timing_q[`ASC_DIV_HI:`ASC_DIV_LO] > `ASC_DIV_MAX) ?
                   `ASC_DIV_MAX : timing_q[`ASC_DIV_HI:`ASC_DIV_LO];

  // write channel handshake: address and data taken in either order
  logic wr_fire, rd_fire;
  assign s_axi_awready = !aw_ok_q && !s_axi_bvalid;
  assign s_axi_wready = !w_ok_q && !s_axi_bvalid;
  assign wr_fire = aw_ok_q && w_ok_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_ok_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_ok_q <= 1'b0;
      end
    end
  end

  // write decode; unmapped addresses answer slverr
  logic wr_map;
  always_comb begin
    wr_map = 1'b1;
    if (aw_q == `ASC_OFF_CTL2) wr_map = 1'b1;
    else if (aw_q == `ASC_OFF_TIMING) wr_map = 1'b1;
    else if (aw_q == `ASC_OFF_SCAN) wr_map = 1'b1;
    else if (aw_q == `ASC_OFF_INSEL) wr_map = 1'b1;
    else if (aw_q == `ASC_OFF_HIT_LO) wr_map = 1'b1;
    else if (aw_q == `ASC_OFF_HIT_HI) wr_map = 1'b1;
    else if (aw_q == `ASC_OFF_RUN) wr_map = 1'b1;
    else wr_map = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_map ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_ctl2, wr_timing, wr_scan, wr_insel, wr_hlo, wr_hhi, wr_run;
  assign wr_ctl2 = wr_fire && (aw_q == `ASC_OFF_CTL2);
  assign wr_timing = wr_fire && (aw_q == `ASC_OFF_TIMING);
  assign wr_scan = wr_fire && (aw_q == `ASC_OFF_SCAN);
  assign wr_insel = wr_fire && (aw_q == `ASC_OFF_INSEL);
  assign wr_hlo = wr_fire && (aw_q == `ASC_OFF_HIT_LO);
  assign wr_hhi = wr_fire && (aw_q == `ASC_OFF_HIT_HI);
  assign wr_run = wr_fire && (aw_q == `ASC_OFF_RUN);

  // plain configuration registers; bit 13 of timing is never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl2_q <= `ASC_RESET_VAL;
      timing_q <= `ASC_RESET_VAL;
      scan_q <= `ASC_RESET_VAL;
      insel_q <= `ASC_RESET_VAL;
    end else begin
      if (wr_ctl2) ctl2_q <= merge(ctl2_q, w_q, ws_q, `ASC_MASK_CTL2);
      if (wr_timing) timing_q <= merge(timing_q, w_q, ws_q, `ASC_MASK_TIMING);
      if (wr_scan) scan_q <= merge(scan_q, w_q, ws_q, `ASC_MASK_SCAN);
      if (wr_insel) insel_q <= merge(insel_q, w_q, ws_q, `ASC_MASK_INSEL);
    end
  end

  // conversion clock: divider on aclk, or the rc tick when selected
  logic div_tick;
  assign div_tick = (div_cnt_q == div_lim);
  always_ff @(posedge aclk) begin
    if (!aresetn || !conv_on || div_tick) begin
      div_cnt_q <= 8'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end
  logic conv_clock_period;
  assign conv_clock_period = conv_on && (src_rc ? rc_clk_tick : div_tick);
  always_ff @(posedge aclk) begin
    if (!aresetn) conv_clk_tick <= 1'b0;
    else conv_clk_tick <= conv_clock_period;
  end

  // end of sampling per source; manual release waits for the next period
  logic sample_enable_end;
  always_comb begin
    sample_enable_end = 1'b0;
    if (state_q == ASC_ST_SAMPLE) begin
      if (src == `ASC_SRC_AUTO) sample_enable_end = conv_clock_period && (auto_sample_time_cnt_q >= auto_sample_time);
      else if (src == `ASC_SRC_SOFT) sample_enable_end = !sample_enable && conv_clock_period;
      else sample_enable_end = trigger_event;
    end
  end

  // run register: sample enable is cleared by the sequencer at end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= `ASC_RESET_VAL;
    end else if (wr_run) begin
      run_q <= merge(run_q, w_q, ws_q, `ASC_MASK_RUN);
    end else if (sample_enable_end && src != `ASC_SRC_SOFT) begin
      run_q[`ASC_SAMPLE_ENABLE_BIT] <= 1'b0;
    end
  end

  // sampling sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn || !conv_on) begin
      state_q <= ASC_ST_IDLE;
      auto_sample_time_cnt_q <= 5'h00;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      case (state_q)
        ASC_ST_IDLE: begin
          auto_sample_time_cnt_q <= 5'h00;
          if (sample_enable) state_q <= ASC_ST_SAMPLE;
        end
        ASC_ST_SAMPLE: begin
          if (conv_clock_period && auto_sample_time_cnt_q != 5'h1f) auto_sample_time_cnt_q <= auto_sample_time_cnt_q + 5'h01;
          if (sample_enable_end) begin
            state_q <= ASC_ST_CONVERT;
            conv_start <= 1'b1;
          end
        end
        ASC_ST_CONVERT: begin
          if (result_in.valid) state_q <= ASC_ST_IDLE;
        end
        default: state_q <= ASC_ST_IDLE;
      endcase
    end
  end

  // sampling level and the extended flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sampling <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      sampling <= (state_q == ASC_ST_SAMPLE) && !sample_enable_end;
      ext_q <= (state_q == ASC_ST_SAMPLE) && !sample_enable && !sample_enable_end;
    end
  end

  // input selection, alternating after each finished conversion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alt_b_q <= 1'b0;
      mux_sel <= '0;
    end else begin
      if (!ctl2_q[`ASC_ALT_BIT]) alt_b_q <= 1'b0;
      else if (state_q == ASC_ST_CONVERT && result_in.valid) alt_b_q <= !alt_b_q;
      // both halves share one code map, so the codes pass straight through
      if (alt_b_q) mux_sel <= insel_q[15:8];
      else mux_sel <= insel_q[7:0];
    end
  end

  // compare and save decision for each result
  logic match, do_save, seq_end, hit_set;
  logic [17:0] hit_vec;
  always_comb begin
    match = result_in.valid && auto_scan && cmp_match(cm, result_in.data, window_in);
    do_save = 1'b0;
    if (result_in.valid) begin
      if (!auto_scan || wm == 2'h0) do_save = 1'b1;
      else if (wm == 2'h1) do_save = match;
      else do_save = 1'b0;
    end
    seq_end = result_in.valid && auto_scan && result_in.last;
    hit_set = match || (auto_scan && cm == 2'h3 && do_save);
    hit_vec = 18'h00000;
    if (hit_set && result_in.chan < 5'h12) hit_vec[result_in.chan] = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) buf_write <= '0;
    else buf_write <= '{en: do_save, addr: result_in.chan, data: result_in.data};
  end

  // sticky hit flags: a new hit wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_lo_q <= 16'h0000;
      hit_hi_q <= 2'h0;
    end else begin
      if (wr_hlo) hit_lo_q <= merge(hit_lo_q, w_q, ws_q, `ASC_MASK_HIT_LO) | hit_vec[15:0];
      else hit_lo_q <= hit_lo_q | hit_vec[15:0];
      if (wr_hhi && ws_q[0]) hit_hi_q <= w_q[1:0] | hit_vec[17:16];
      else hit_hi_q <= hit_hi_q | hit_vec[17:16];
    end
  end

  // threshold event per interrupt mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      threshold_event <= 1'b0;
      match_seen_q <= 1'b0;
    end else begin
      case (irqm)
        2'h3: threshold_event <= seq_end && (match_seen_q || match);
        2'h2: threshold_event <= match;
        2'h1: threshold_event <= seq_end;
        default: threshold_event <= 1'b0;
      endcase
      if (seq_end) match_seen_q <= 1'b0;
      else if (match) match_seen_q <= 1'b1;
    end
  end

  // power and reference requests
  logic active;
  assign active = conv_on && (state_q != ASC_ST_IDLE);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      full_power <= 1'b0;
      charge_unit_enable <= 1'b0;
      band_gap_enable <= 1'b0;
    end else begin
      if (!conv_on) full_power <= 1'b0;
      else if (seq_end && lp_ret) full_power <= 1'b0;
      else if (active) full_power <= 1'b1;
      charge_unit_enable <= scan_q[`ASC_CHARGE_UNIT_REQUEST_BIT] && active;
      band_gap_enable <= scan_q[`ASC_BAND_GAP_REQUEST_BIT] && active;
    end
  end

  // read path, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      if (s_axi_araddr == `ASC_OFF_CTL2) s_axi_rdata <= {16'h0000, ctl2_q};
      else if (s_axi_araddr == `ASC_OFF_TIMING)
        s_axi_rdata <= {16'h0000, timing_q[15], ext_q, timing_q[13:0]};
      else if (s_axi_araddr == `ASC_OFF_SCAN) s_axi_rdata <= {16'h0000, scan_q};
      else if (s_axi_araddr == `ASC_OFF_INSEL) s_axi_rdata <= {16'h0000, insel_q};
      else if (s_axi_araddr == `ASC_OFF_HIT_LO) s_axi_rdata <= {16'h0000, hit_lo_q};
      else if (s_axi_araddr == `ASC_OFF_HIT_HI) s_axi_rdata <= {30'h0, hit_hi_q};
      else if (s_axi_araddr == `ASC_OFF_RUN) s_axi_rdata <= {16'h0000, run_q};
      else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'h2;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### asc_scan_ctrl_sva.sv
/*
  checker of the scan and threshold control block's ports.
  assumes it is bound to asc_scan_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module asc_scan_ctrl_sva
  import asc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire asc_result_s result_in,
  input wire asc_bufwr_s buf_write,
  input wire logic threshold_event,
  input wire logic conv_start,
  input wire logic sampling,
  input wire logic full_power
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // responses stand until the master takes them
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  a_rresp_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read response changed before rready");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during response");
  // a buffer write carries the result of the cycle before
  a_bufw_follows: assert property (buf_write.en |->
    $past(result_in.valid) && buf_write.data == $past(result_in.data))
    else $error("buffer write without matching result");
  a_event_follows: assert property (threshold_event |-> $past(result_in.valid))
    else $error("threshold event without result");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  a_reset_quiet: assert property (!$past(aresetn) |->
    !s_axi_bvalid && !s_axi_rvalid && !sampling && !full_power && !conv_start)
    else $error("outputs active after reset");

  cover property (buf_write.en);
  cover property (threshold_event);
  cover property (sampling ##1 conv_start);
endmodule

bind asc_scan_ctrl asc_scan_ctrl_sva i_sva (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .result_in,
  .buf_write, .threshold_event, .conv_start, .sampling, .full_power);

`default_nettype wire

// ### asc_core_model.sv
/*
  stand-in for the analog core: rc tick and delayed results.
  assumes the controller's aclk domain and its conv_start pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module asc_core_model
  import asc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic conv_start,
  input wire asc_mux_s mux_sel,
  input wire logic [11:0] data,
  input wire logic last,
  input wire asc_window_s win,
  output asc_result_s result_in,
  output asc_window_s window_in,
  output logic rc_clk_tick
);
  logic [2:0] rc_q;
  logic [2:0] dl_q;
  logic ok;

  // rc tick every five cycles, unrelated to any divider value
  always_ff @(posedge aclk) begin
    if (!aresetn) rc_q <= 3'h0;
    else rc_q <= (rc_q == 3'h4) ? 3'h0 : rc_q + 3'h1;
  end

  // hold and convert for six cycles after the start pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) dl_q <= 3'h0;
    else if (conv_start) dl_q <= 3'h6;
    else if (dl_q != 3'h0) dl_q <= dl_q - 3'h1;
  end

  // outside the valid cycle the lines carry inverted junk, never stale data
  assign ok = (dl_q == 3'h1);
  assign rc_clk_tick = (rc_q == 3'h4);
  assign result_in = '{ok, last, mux_sel.pos, ok ? data : ~data};
  assign window_in = ok ? win : ~win;
endmodule

`default_nettype wire

// ### asc_scan_ctrl_tb.sv
/*
  self-checking bench of the scan and threshold control block.
  assumes asc_pkg, asc_cfg.svh, the core model and the checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "asc_cfg.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module asc_scan_ctrl_tb
  import asc_pkg::*;
;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, trigger_event = 0, ml = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rc_clk_tick;
  logic conv_clk_tick, sampling, conv_start, threshold_event, full_power, bw, te;
  logic charge_unit_enable, band_gap_enable;
  logic [11:0] md = '0;
  asc_window_s mw = '{12'h064, 12'h0c8};
  asc_result_s result_in;
  asc_window_s window_in;
  asc_mux_s mux_sel, mx;
  asc_bufwr_s buf_write;
  int mismatches = 0, check_count = 0, cyc = 0, t_s = 0, t_c = 0;

  asc_scan_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rc_clk_tick, .trigger_event, .result_in, .window_in,
    .conv_clk_tick, .sampling, .conv_start, .mux_sel, .buf_write, .threshold_event,
    .full_power, .charge_unit_enable, .band_gap_enable);
  asc_core_model i_core (.aclk, .aresetn, .conv_start, .mux_sel, .data(md), .last(ml),
    .win(mw), .result_in, .window_in, .rc_clk_tick);

  // 125 mhz clock
  initial forever #4 aclk = ~aclk;

  // cycle count, hang guard and timestamp of the conversion start
  always @(negedge aclk) begin
    cyc++;
    if (conv_start) begin
      t_c = cyc;
      mx = mux_sel;
    end
    if (cyc == 50000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // handshakes sampled at the falling edge, where ready levels are settled
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = 2'b00);
    logic ga, gw, g;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    g = 1'b0;
    while (!g) begin
      @(negedge aclk);
      ga = s_axi_awready;
      gw = s_axi_wready;
      g = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    `CHK(r, er)
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er = 2'b00);
    logic ga, g;
    logic [15:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    g = 1'b0;
    while (!g) begin
      @(negedge aclk);
      ga = s_axi_arready;
      g = s_axi_rvalid;
      d = s_axi_rdata[15:0];
      r = s_axi_rresp;
      @(posedge aclk);
      if (ga) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    `CHK(d, e)
    `CHK(r, er)
  endtask

  // wait for a result, then catch the pulses one cycle later
  task automatic wres();
    do @(negedge aclk); while (result_in.valid !== 1'b1);
    @(negedge aclk);
    bw = buf_write.en;
    te = threshold_event;
  endtask

  // source 1: sampling runs until the trigger pulse
  task automatic go(input logic [11:0] d, input logic l);
    md <= d;
    ml <= l;
    wr(`ASC_OFF_RUN, 16'h8012);
  endtask

  task automatic fin();
    @(posedge aclk);
    trigger_event <= 1'b1;
    @(posedge aclk);
    trigger_event <= 1'b0;
    wres();
  endtask

  task automatic conv(input logic [11:0] d, input logic l);
    go(d, l);
    fin();
  endtask

  // first period after a change may be partial, so it is skipped
  task automatic per(input int e);
    int p;
    do @(negedge aclk); while (conv_clk_tick !== 1'b1);
    do @(negedge aclk); while (conv_clk_tick !== 1'b1);
    p = 0;
    do begin
      @(negedge aclk);
      p++;
    end while (conv_clk_tick !== 1'b1);
    `CHK(p, e)
  endtask

  task automatic t_regs();
    logic [7:0] of [6] = '{`ASC_OFF_CTL2, `ASC_OFF_TIMING, `ASC_OFF_SCAN, `ASC_OFF_INSEL,
      `ASC_OFF_HIT_LO, `ASC_OFF_HIT_HI};
    logic [15:0] mk [6] = '{16'h0001, 16'h9fff, 16'hf30f, 16'hffff, 16'hffff, 16'h0003};
    rchk(`ASC_OFF_RUN, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      rchk(of[i], 16'h0000);
      wr(of[i], (i == 1) ? 16'hdfff : 16'hffff);
      rchk(of[i], mk[i]);
      wr(of[i], 16'h0000);
    end
    rchk(`ASC_OFF_HIT_HI, 16'h0000);
    wr(8'h1c, 16'hffff, 2'b10);
    rchk(8'h1c, 16'h0000, 2'b10);
  endtask

  int mk [2] = '{31, 0};

  task automatic t_clk();
    wr(`ASC_OFF_RUN, 16'h8000);
    wr(`ASC_OFF_TIMING, 16'h0003);
    per(4);
    wr(`ASC_OFF_TIMING, 16'h0050);
    per(64);
    wr(`ASC_OFF_TIMING, 16'h8003);
    per(5);
    wr(`ASC_OFF_TIMING, 16'h0000);
    per(1);
    // auto scan stays off while the counter source is used
    foreach (mk[i]) begin
      wr(`ASC_OFF_TIMING, {3'h0, mk[i][4:0], 8'h01});
      wr(`ASC_OFF_RUN, 16'h8072);
      t_s = cyc;
      wres();
      `CHK(t_c - t_s >= 2 * mk[i] - 2 && t_c - t_s <= 2 * mk[i] + 4, 1'b1)
    end
  endtask

  task automatic t_soft();
    wr(`ASC_OFF_TIMING, 16'h003f);
    wr(`ASC_OFF_RUN, 16'h8002);
    repeat (2) @(negedge aclk);
    `CHK(sampling, 1'b1)
    do @(negedge aclk); while (conv_clk_tick !== 1'b1);
    wr(`ASC_OFF_RUN, 16'h8000);
    rchk(`ASC_OFF_TIMING, 16'h403f);
    wres();
    rchk(`ASC_OFF_TIMING, 16'h003f);
    `CHK(sampling, 1'b0)
    wr(`ASC_OFF_TIMING, 16'h0000);
  endtask

  task automatic t_alt();
    wr(`ASC_OFF_INSEL, 16'h4523);
    wr(`ASC_OFF_CTL2, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      if (i == 3) wr(`ASC_OFF_CTL2, 16'h0000);
      conv(12'h000, 1'b0);
      `CHK(mx, (i == 1) ? 8'h45 : 8'h23)
    end
  endtask

  task automatic t_cmp();
    logic [11:0] dt [8] = '{12'h096, 12'h032, 12'h032, 12'h096,
      12'h0fa, 12'h096, 12'h096, 12'h0fa};
    wr(`ASC_OFF_INSEL, 16'h0002);
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 2; k++) begin
        wr(`ASC_OFF_HIT_LO, 16'h0000);
        wr(`ASC_OFF_SCAN, 16'h8204 | c[1:0]);
        conv(dt[2 * c + k], 1'b0);
        `CHK(bw, k[0])
        `CHK(te, k[0])
        rchk(`ASC_OFF_HIT_LO, k ? 16'h0004 : 16'h0000);
      end
    end
    conv(12'h096, 1'b0);
    rchk(`ASC_OFF_HIT_LO, 16'h0004);
    wr(`ASC_OFF_HIT_LO, 16'h0000);
    rchk(`ASC_OFF_HIT_LO, 16'h0000);
    wr(`ASC_OFF_SCAN, 16'h8208);
    conv(12'h032, 1'b0);
    `CHK({bw, te}, 2'b01)
    wr(`ASC_OFF_SCAN, 16'h8000);
    conv(12'h096, 1'b0);
    `CHK({bw, te}, 2'b10)
    wr(`ASC_OFF_SCAN, 16'h8100);
    conv(12'h096, 1'b1);
    `CHK(te, 1'b1)
    wr(`ASC_OFF_SCAN, 16'h8300);
    conv(12'h096, 1'b1);
    `CHK(te, 1'b0)
    conv(12'h032, 1'b1);
    `CHK(te, 1'b1)
  endtask

  task automatic t_pwr();
    wr(`ASC_OFF_SCAN, 16'hf000);
    go(12'h096, 1'b1);
    repeat (2) @(negedge aclk);
    `CHK({full_power, charge_unit_enable, band_gap_enable}, 3'h7)
    fin();
    `CHK(full_power, 1'b0)
    wr(`ASC_OFF_SCAN, 16'h8000);
    go(12'h096, 1'b1);
    repeat (2) @(negedge aclk);
    `CHK({charge_unit_enable, band_gap_enable}, 2'h0)
    fin();
    `CHK(full_power, 1'b1)
    wr(`ASC_OFF_SCAN, 16'h0004);
    conv(12'h096, 1'b0);
    `CHK(bw, 1'b1)
  endtask

  // reset for eight cycles, then the scenarios in turn
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_clk();
    t_soft();
    t_alt();
    t_cmp();
    t_pwr();
    give_verdict();
  end
endmodule

`default_nettype wire
